// file: design/acdr_map.svh
// Constants for the asynchronous receive clock and data recovery block
`ifndef ACDR_MAP_SVH
`define ACDR_MAP_SVH
`define ACDR_MODE_NORMAL   2'h0
`define ACDR_MODE_DOUBLE   2'h1
`define ACDR_SPB_NORMAL    5'h10
`define ACDR_SPB_DOUBLE    5'h08
`define ACDR_VOTE_A_NORMAL 5'h08
`define ACDR_VOTE_A_DOUBLE 5'h04
`define ACDR_DBITS_MIN     4'h5
`define ACDR_DBITS_MAX     4'ha
`define ACDR_DBITS_RESET   4'h8
`endif

// file: design/acdr_pkg.sv
// Types for the asynchronous receive clock and data recovery block
package acdr_pkg;
	typedef enum logic [1:0] {ACDR_IDLE, ACDR_START, ACDR_DATA, ACDR_STOP} acdr_state_e;
	typedef struct packed {
		logic [9:0] data;
		logic       frameErr;
	} acdr_frame_s;
endpackage : acdr_pkg

// file: design/acdr_buf2.sv
// Two-entry valid/ready buffer for received frames
`timescale 1ns/1ps
module acdr_buf2
	import acdr_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        ce,
	input  wire logic        inValid,
	output logic             inReady,
	input  wire acdr_frame_s inData,
	output logic             outValid,
	input  wire logic        outReady,
	output acdr_frame_s      outData
);
	acdr_frame_s mem [2];
	logic        wrPtr;
	logic        rdPtr;
	logic [1:0]  count;
	logic        push;
	logic        pop;

	assign inReady  = (count != 2'h2);
	assign outValid = (count != 2'h0);
	assign push     = ce & inValid & inReady;
	assign pop      = ce & outValid & outReady;
	assign outData  = mem[rdPtr];

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mem[0] <= '0;
			mem[1] <= '0;
		end else if (push) begin
			mem[wrPtr] <= inData;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wrPtr <= 1'b0;
			rdPtr <= 1'b0;
			count <= 2'h0;
		end else begin
			if (push)
				wrPtr <= ~wrPtr;
			if (pop)
				rdPtr <= ~rdPtr;
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule : acdr_buf2

// file: design/acdr_rx.sv
// Asynchronous receiver: start-bit qualification, majority-vote data recovery
//
// Contract
// - Sixteen samples per bit, eight in double speed
// - Falling edge starts detection; first low is sample one
// - Normal mode qualifies on samples 8, 9, 10
// - Double speed qualifies on samples 4, 5, 6
// - Two of three low accepts, resyncs timing
// - Fewer than two low rejects; await next edge
// - Each bit decided by three-sample majority
// - Only the first stop bit is sampled
// - Low voted stop bit sets frame error
// - Normal mode: next edge right after stop votes
// - Double speed: next low after vote samples
// - Mode value 0x01 selects double speed
`timescale 1ns/1ps
`include "acdr_map.svh"
module acdr_rx
	import acdr_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        ce,
	input  wire logic        rxEnable,
	input  wire logic [1:0]  receiveSamplingModeField,
	input  wire logic [3:0]  dataBits,
	input  wire logic        sampleTick,
	input  wire logic        rxPin,
	output logic             frameValid,
	input  wire logic        frameReady,
	output acdr_frame_s      frameOut,
	output logic             overrun,
	output logic             busy
);
	logic        rxSync1;
	logic        rxSync2;
	logic        rxPrev;
	acdr_state_e state;
	logic [4:0]  sampleCnt;
	logic [3:0]  bitCnt;
	logic [1:0]  lowVotes;
	logic [1:0]  highVotes;
	logic [9:0]  shiftReg;
	logic        doubleMode;
	logic [3:0]  frameBits;
	logic [4:0]  spb;
	logic [4:0]  voteA;
	logic        inVote;
	logic        voteEnd;
	logic        voteHigh;
	logic        fallEdge;
	logic        pushValid;
	logic        pushReady;
	acdr_frame_s pushData;
	logic [3:0]  alignShift;

	// Decoded per-tick events
	logic        tickEn;
	logic        wrapCnt;
	logic        voteLow;
	logic        startAccept;
	logic        startReject;
	logic        dataVoteDone;
	logic        lastDataBit;
	logic        stopVoteDone;

	// Next values, one process per register group
	acdr_state_e next_state;
	logic [4:0]  next_sampleCnt;
	logic [1:0]  next_lowVotes;
	logic [1:0]  next_highVotes;
	logic [3:0]  next_bitCnt;
	logic [9:0]  next_shiftReg;

	// Two flops on the pin before any logic looks at it
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rxSync1 <= 1'b1;
			rxSync2 <= 1'b1;
		end else if (ce) begin
			rxSync1 <= rxPin;
			rxSync2 <= rxSync1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			rxPrev <= 1'b1;
		else if (ce && sampleTick)
			rxPrev <= rxSync2;
	end

	assign doubleMode = (receiveSamplingModeField == `ACDR_MODE_DOUBLE);
	assign spb   = doubleMode ? `ACDR_SPB_DOUBLE : `ACDR_SPB_NORMAL;
	assign voteA = doubleMode ? `ACDR_VOTE_A_DOUBLE : `ACDR_VOTE_A_NORMAL;
	// Out-of-range sizes clamp so a frame always terminates
	assign frameBits = (dataBits < `ACDR_DBITS_MIN) ? `ACDR_DBITS_MIN :
		(dataBits > `ACDR_DBITS_MAX) ? `ACDR_DBITS_MAX : dataBits;

	// Sample counter is 1-based from the first low sample
	assign inVote   = (sampleCnt >= voteA) && (sampleCnt <= voteA + 5'h02);
	assign voteEnd  = (sampleCnt == voteA + 5'h02);
	assign fallEdge = rxPrev & ~rxSync2;
	// Majority of three including the sample being taken now
	assign voteHigh = ((highVotes + {1'b0, rxSync2}) >= 2'h2);

	// Strobes shared by the per-register processes below
	assign tickEn       = rxEnable && sampleTick;
	assign wrapCnt      = (sampleCnt == spb);
	assign voteLow      = ((lowVotes + {1'b0, ~rxSync2}) >= 2'h2);
	assign startAccept  = (state == ACDR_START) && voteEnd && voteLow;
	assign startReject  = (state == ACDR_START) && voteEnd && !voteLow;
	assign dataVoteDone = (state == ACDR_DATA) && voteEnd;
	assign lastDataBit  = dataVoteDone && ((bitCnt + 4'h1) == frameBits);
	assign stopVoteDone = (state == ACDR_STOP) && voteEnd;

	always_comb begin
		next_state = state;
		if (!rxEnable) begin
			next_state = ACDR_IDLE;
		end else if (sampleTick) begin
			unique case (state)
				ACDR_IDLE: begin
					// Idle re-arms right after the stop votes, no full stop bit wait
					if (fallEdge)
						next_state = ACDR_START;
				end
				ACDR_START: begin
					if (startAccept)
						next_state = ACDR_DATA;
					else if (startReject)
						next_state = ACDR_IDLE;
				end
				ACDR_DATA: begin
					if (lastDataBit)
						next_state = ACDR_STOP;
				end
				ACDR_STOP: begin
					// Only the first stop bit is voted; later ones look idle
					if (stopVoteDone)
						next_state = ACDR_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= ACDR_IDLE;
		end else if (ce) begin
			state <= next_state;
		end
	end

	// Counter is 1-based; start state never wraps since its votes end early
	always_comb begin
		next_sampleCnt = sampleCnt;
		if (!rxEnable) begin
			next_sampleCnt = 5'h00;
		end else if (sampleTick) begin
			unique case (state)
				ACDR_IDLE: begin
					if (fallEdge)
						next_sampleCnt = 5'h02;
				end
				ACDR_START: begin
					next_sampleCnt = sampleCnt + 5'h01;
				end
				ACDR_DATA, ACDR_STOP: begin
					if (wrapCnt)
						next_sampleCnt = 5'h01;
					else
						next_sampleCnt = sampleCnt + 5'h01;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sampleCnt <= 5'h00;
		end else if (ce) begin
			sampleCnt <= next_sampleCnt;
		end
	end

	// Votes restart on the detected edge and at every bit boundary
	always_comb begin
		next_lowVotes  = lowVotes;
		next_highVotes = highVotes;
		if (!rxEnable) begin
			next_lowVotes  = 2'h0;
			next_highVotes = 2'h0;
		end else if (sampleTick) begin
			unique case (state)
				ACDR_IDLE: begin
					if (fallEdge) begin
						next_lowVotes  = 2'h0;
						next_highVotes = 2'h0;
					end
				end
				ACDR_START: begin
					if (inVote) begin
						next_lowVotes  = lowVotes + {1'b0, ~rxSync2};
						next_highVotes = highVotes + {1'b0, rxSync2};
					end
				end
				ACDR_DATA, ACDR_STOP: begin
					if (wrapCnt) begin
						next_lowVotes  = 2'h0;
						next_highVotes = 2'h0;
					end else if (inVote) begin
						next_lowVotes  = lowVotes + {1'b0, ~rxSync2};
						next_highVotes = highVotes + {1'b0, rxSync2};
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lowVotes  <= 2'h0;
			highVotes <= 2'h0;
		end else if (ce) begin
			lowVotes  <= next_lowVotes;
			highVotes <= next_highVotes;
		end
	end

	// Disabling drops the word in flight and clears it; an accepted start also clears it
	always_comb begin
		next_bitCnt = bitCnt;
		if (!rxEnable) begin
			next_bitCnt = 4'h0;
		end else if (sampleTick) begin
			if (startAccept)
				next_bitCnt = 4'h0;
			else if (dataVoteDone)
				next_bitCnt = bitCnt + 4'h1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bitCnt <= 4'h0;
		end else if (ce) begin
			bitCnt <= next_bitCnt;
		end
	end

	always_comb begin
		next_shiftReg = shiftReg;
		if (!rxEnable) begin
			next_shiftReg = 10'h000;
		end else if (sampleTick) begin
			if (startAccept)
				next_shiftReg = 10'h000;
			else if (dataVoteDone)
				next_shiftReg = {voteHigh, shiftReg[9:1]};
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			shiftReg <= 10'h000;
		end else if (ce) begin
			shiftReg <= next_shiftReg;
		end
	end

	// Frame leaves as the stop votes complete
	assign pushValid  = ce && tickEn && stopVoteDone;
	assign alignShift = 4'ha - frameBits;

	always_comb begin
		pushData.data = shiftReg >> alignShift;
		pushData.frameErr = ~voteHigh;
	end

	// Buffer full on completion drops the word and flags it
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			overrun <= 1'b0;
		else if (ce)
			overrun <= pushValid & ~pushReady;
	end

	assign busy = (state != ACDR_IDLE);

	acdr_buf2 u_buf (
		.clk      (clk),
		.nrst     (nrst),
		.ce       (ce),
		.inValid  (pushValid),
		.inReady  (pushReady),
		.inData   (pushData),
		.outValid (frameValid),
		.outReady (frameReady),
		.outData  (frameOut)
	);
endmodule : acdr_rx

// file: verification/acdr_rx_asserts.sv
// Port assertions for the receiver
`timescale 1ns/1ps
module acdr_rx_asserts
	import acdr_pkg::*;
(
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        ce,
	input wire logic        rxEnable,
	input wire logic        rxPin,
	input wire logic        frameValid,
	input wire logic        frameReady,
	input wire acdr_frame_s frameOut,
	input wire logic        overrun,
	input wire logic        busy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence heldS;
		frameValid && !(frameReady && ce);
	endsequence
	hold_out_a: assert property (heldS |=> frameValid && $stable(frameOut))
		else $error("held frame changed");
	start_edge_a: assert property ($rose(busy) |-> !($past(rxPin, 2) && $past(rxPin, 3)))
		else $error("busy without a low line");
	frame_len_a: assert property ($rose(frameValid) |-> $past(busy, 2) && $past(busy, 40))
		else $error("frame too short");
	enable_off_a: assert property (!rxEnable && ce |=> !busy)
		else $error("busy while disabled");
	ce_freeze_a: assert property (!ce |=> $stable(busy) && $stable(frameValid))
		else $error("moved while frozen");
	overrun_full_a: assert property (overrun |-> frameValid)
		else $error("overrun with room");
	no_spont_a: assert property (!busy && !$past(busy) && !frameValid |=> !frameValid)
		else $error("frame from idle");
	reset_clear_a: assert property (disable iff (1'b0) !nrst |-> !frameValid && !busy)
		else $error("outputs set in reset");
endmodule : acdr_rx_asserts
bind acdr_rx acdr_rx_asserts chk_u (.clk(clk), .nrst(nrst), .ce(ce), .rxEnable(rxEnable),
	.rxPin(rxPin), .frameValid(frameValid), .frameReady(frameReady), .frameOut(frameOut),
	.overrun(overrun), .busy(busy));

// file: verification/acdr_tx_model.sv
// Remote transmitter model, exact bit rate
`timescale 1ns/1ps
module acdr_tx_model (
	input  wire logic clk,
	output logic      line
);
	initial line = 1'b1;
	// Stop length in samples lets the next start come early
	task automatic send(input logic [9:0] d, input int n, s, stp, input logic sb);
		line <= 1'b0;
		repeat (s) @(negedge clk);
		for (int i = 0; i < n; i++) begin
			line <= d[i];
			repeat (s) @(negedge clk);
		end
		line <= sb;
		repeat (stp) @(negedge clk);
		// A high stop already idles the line, so back to back frames follow at once
		if (!sb)
			line <= 1'b1;
	endtask : send
endmodule : acdr_tx_model

// file: verification/async_rx_clock_data_recovery_tb_top.sv
// Self-checking bench for the receiver
`timescale 1ns/1ps
module async_rx_clock_data_recovery_tb_top;
	import acdr_pkg::*;
	logic        clk = 0, nrst = 1, ce = 1, rxEnable = 0, frameReady = 0;
	int          ovCount = 0;
	logic [1:0]  mode = 2'h0;
	logic [3:0]  dataBits = 4'h8;
	logic        rxPin, frameValid, overrun, busy;
	acdr_frame_s frameOut;
	int          num_errors = 0, n_checks = 0;
	always #4 clk = ~clk;
	always @(posedge clk) if (overrun) ovCount <= ovCount + 1;
	acdr_tx_model tx_u (.clk(clk), .line(rxPin));
	acdr_rx dut_u (.clk(clk), .nrst(nrst), .ce(ce), .rxEnable(rxEnable),
		.receiveSamplingModeField(mode), .dataBits(dataBits), .sampleTick(1'b1),
		.rxPin(rxPin), .frameValid(frameValid), .frameReady(frameReady),
		.frameOut(frameOut), .overrun(overrun), .busy(busy));
	task automatic print_verdict;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict
	task automatic cmp(input logic [10:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask : cmp
	// Head frame must survive a frozen ce before the pop
	task automatic get(input logic [10:0] exp);
		int k;
		for (k = 0; k < 500 && frameValid !== 1'b1; k++) @(negedge clk);
		if (k == 500) begin
			cmp(0, 1);
			print_verdict();
		end else begin
			ce = 0;
			repeat (3) @(negedge clk);
			cmp(frameValid, 1);
			cmp(frameOut, exp);
			ce = 1;
			frameReady = 1;
			@(negedge clk);
			frameReady = 0;
		end
	endtask : get
	task automatic t_frames;
		for (int m = 0; m < 2; m++) for (int n = 5; n < 11; n += 5) for (int f = 0; f < 2; f++) begin
			mode = 2'(m);
			dataBits = 4'(n);
			tx_u.send(10'h2b5, n, 16 >> m, 16 >> m, !f[0]);
			get({10'h2b5 & ~(10'h3ff << n), f[0]});
		end
		$display("frames done");
	endtask : t_frames
	task automatic t_b2b;
		int ov0;
		dataBits = 4'h8;
		for (int m = 0; m < 2; m++) begin
			mode = 2'(m);
			ov0 = ovCount;
			tx_u.send(10'h0a5, 8, 16 >> m, m ? 6 : 10, 1);
			tx_u.send(10'h05a, 8, 16 >> m, m ? 6 : 10, 1);
			tx_u.send(10'h0ff, 8, 16 >> m, 16 >> m, 1);
			repeat (20) @(negedge clk);
			cmp(11'(ovCount - ov0), 11'h001);
			get({10'h0a5, 1'b0});
			get({10'h05a, 1'b0});
		end
		$display("back to back done");
	endtask : t_b2b
	task automatic t_rej;
		mode = 2'h0;
		tx_u.send(10'h0, 0, 8, 0, 1);
		repeat (200) @(negedge clk);
		cmp(frameValid, 0);
		mode = 2'h3;
		tx_u.send(10'h0, 0, 9, 0, 1);
		get({10'h0ff, 1'b0});
		$display("start vote done");
	endtask : t_rej
	// Disable mid-frame; an all-ones word leaves no later falling edge
	task automatic t_off;
		mode = 2'h0;
		dataBits = 4'h8;
		fork
			tx_u.send(10'h3ff, 8, 16, 16, 1);
			begin
				repeat (40) @(negedge clk);
				cmp(busy, 1);
				rxEnable = 0;
				@(negedge clk);
				cmp(busy, 0);
				rxEnable = 1;
			end
		join
		repeat (20) @(negedge clk);
		cmp(frameValid, 0);
		$display("disable done");
	endtask : t_off
	initial begin
		// A real falling edge clears the design before the first clock
		#1 nrst = 0;
		repeat (5) @(negedge clk);
		nrst = 1;
		rxEnable = 1;
		repeat (5) @(negedge clk);
		t_frames();
		t_b2b();
		t_rej();
		t_off();
		print_verdict();
	end
endmodule : async_rx_clock_data_recovery_tb_top
